// *** hdl/tmc_ctrl.sv ***
/*
 * timer control/status register, flag logic, mode decode,
 * capture/reload strobes, serial clock steering and interrupts.
 * assumes the counter datapath sends a one-cycle overflow pulse,
 * all inputs are synchronous to clk_sys, and the bus master never
 * raises two strobes at once.
 */
`timescale 1ns/1ps
`include "tmc_map.svh"
module tmc_ctrl
  import tmc_pkg::*;
(
  input wire logic clk_sys, // core clock, 200 MHz
  input wire logic srst, // sync reset, active high
  input wire logic [7:0] reg_addr, // byte or bit address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // byte write strobe
  input wire logic reg_rd, // byte read strobe
  input wire logic bit_wr, // bit write strobe
  input wire logic bit_rd, // bit read strobe
  output logic [7:0] reg_rdata, // read data, cycle after
  input wire logic timer_ovf, // counter overflow pulse
  input wire logic external_trigger_pin, // trigger input
  input wire logic timer_int_en, // timer interrupt enable
  input wire logic alt_rx_tick, // other timer rx tick
  input wire logic alt_tx_tick, // other timer tx tick
  output tmc_mode_t mode, // decoded operating mode
  output logic count_run, // counter runs
  output logic count_external, // count pin edges
  output logic capture_pulse, // load capture regs
  output logic reload_pulse, // reload counter
  output logic down_count_enable, // up/down mode active
  output logic rx_clk_tick, // serial receive clock
  output logic tx_clk_tick, // serial transmit clock
  output logic timer_irq_req, // timer interrupt request
  output logic irq // status interrupt level
);

  // ****************************************
  // declarations
  // ****************************************
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic down_count_enable_r;
  logic down_count_enable_nxt;
  logic pin_q_r;
  logic pin_q_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  tmc_mode_t mode_r;
  tmc_mode_t mode_nxt;
  logic cap_r;
  logic cap_nxt;
  logic rel_r;
  logic rel_nxt;
  logic rx_r;
  logic rx_nxt;
  logic tx_r;
  logic tx_nxt;
  logic run_r;
  logic run_nxt;
  logic ext_cnt_r;
  logic ext_cnt_nxt;
  logic req_r;
  logic req_nxt;
  logic pin_fall;
  logic clk_sel;
  logic ext_enabled;
  logic ext_capture;
  logic ext_reload;
  logic ovf_reload;
  logic ovf_set;
  logic ext_set;
  logic ctrl_hit;
  logic mode_hit;
  logic bit_hit;
  logic [2:0] bit_idx;
  logic ext_irq_ok;

  tmc_irq_if irq_bus();

  // ****************************************
  // address decode
  // ****************************************
  assign ctrl_hit = (reg_addr == `TMC_CTRL_OFS);
  assign mode_hit = (reg_addr == `TMC_MODE_OFS);
  // bit addresses occupy base..base+7, one per control bit
  assign bit_hit = (reg_addr[7:3] == `TMC_BIT_BASE >> 3);
  assign bit_idx = reg_addr[2:0];

  // ****************************************
  // trigger edge and event qualification
  // ****************************************
  // pin is synchronous, so one delay stage is enough
  always_comb begin
    pin_q_nxt = external_trigger_pin;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pin_q_r <= 1'h1;
    end else begin
      pin_q_r <= pin_q_nxt;
    end
  end

  assign pin_fall = pin_q_r & ~external_trigger_pin;
  assign clk_sel = ctrl_r[`TMC_B_RCLK] | ctrl_r[`TMC_B_TRANSMIT_CLOCK_SELECT];
  assign ext_enabled = pin_fall & ctrl_r[`TMC_B_EXEN];

  // clock selects override capture and force reload
  assign ext_capture = ext_enabled & ctrl_r[`TMC_B_CPRL]
                       & ~clk_sel;
  // in up/down mode the pin steers direction, not reloads
  assign ext_reload = ext_enabled & ~ctrl_r[`TMC_B_CPRL]
                      & ~clk_sel & ~down_count_enable_r;
  assign ovf_reload = timer_ovf
                      & (~ctrl_r[`TMC_B_CPRL] | clk_sel);

  assign ovf_set = timer_ovf & ~clk_sel;
  assign ext_set = ext_capture | ext_reload;

  // ****************************************
  // control/status register
  // ****************************************
  // hardware sets are applied after software writes, so a flag
  // raised in the same cycle as its clear survives
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (reg_wr && ctrl_hit) begin
      ctrl_nxt = reg_wdata;
    end
    if (bit_wr && bit_hit) begin
      ctrl_nxt[bit_idx] = reg_wdata[0];
    end
    if (ovf_set) begin
      ctrl_nxt[`TMC_B_OVF] = 1'h1;
    end
    if (ext_set) begin
      ctrl_nxt[`TMC_B_EXT] = 1'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_r <= `TMC_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ****************************************
  // mode control register
  // ****************************************
  always_comb begin
    down_count_enable_nxt = down_count_enable_r;
    if (reg_wr && mode_hit) begin
      down_count_enable_nxt = reg_wdata[`TMC_B_DOWN_COUNT_ENABLE];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      down_count_enable_r <= `TMC_DOWN_COUNT_ENABLE_RST;
    end else begin
      down_count_enable_r <= down_count_enable_nxt;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // unmapped and write-only addresses read as zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `TMC_CTRL_OFS: rdata_nxt = ctrl_r;
        `TMC_MODE_OFS: rdata_nxt = {7'h00, down_count_enable_r};
        `TMC_STAT_OFS: rdata_nxt = {6'h00, irq_bus.status};
        `TMC_IEN_OFS: rdata_nxt = {6'h00, irq_bus.ien};
        default: rdata_nxt = 8'h00;
      endcase
    end else if (bit_rd && bit_hit) begin
      rdata_nxt = {7'h00, ctrl_r[bit_idx]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************
  // mode decode
  // ****************************************
  always_comb begin
    mode_nxt = TMC_OFF;
    case ({ctrl_r[`TMC_B_RUN], clk_sel, ctrl_r[`TMC_B_CPRL]})
      3'h4: mode_nxt = TMC_RELOAD;
      3'h5: mode_nxt = TMC_CAPTURE;
      3'h6: mode_nxt = TMC_BAUD;
      3'h7: mode_nxt = TMC_BAUD;
      default: mode_nxt = TMC_OFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_r <= TMC_OFF;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  assign mode = mode_r;

  // ****************************************
  // datapath strobes and selects
  // ****************************************
  // one cycle of latency keeps every strobe and select a flip-flop
  always_comb begin
    cap_nxt = ext_capture;
    rel_nxt = ovf_reload | ext_reload;
    run_nxt = ctrl_r[`TMC_B_RUN];
    ext_cnt_nxt = ctrl_r[`TMC_B_CT];
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cap_r <= 1'h0;
      rel_r <= 1'h0;
      run_r <= 1'h0;
      ext_cnt_r <= 1'h0;
    end else begin
      cap_r <= cap_nxt;
      rel_r <= rel_nxt;
      run_r <= run_nxt;
      ext_cnt_r <= ext_cnt_nxt;
    end
  end

  assign capture_pulse = cap_r;
  assign reload_pulse = rel_r;
  assign count_run = run_r;
  assign count_external = ext_cnt_r;
  assign down_count_enable = down_count_enable_r;

  // ****************************************
  // serial port clock steering
  // ****************************************
  always_comb begin
    rx_nxt = ctrl_r[`TMC_B_RCLK] ? timer_ovf : alt_rx_tick;
    tx_nxt = ctrl_r[`TMC_B_TRANSMIT_CLOCK_SELECT] ? timer_ovf : alt_tx_tick;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_r <= 1'h0;
      tx_r <= 1'h0;
    end else begin
      rx_r <= rx_nxt;
      tx_r <= tx_nxt;
    end
  end

  assign rx_clk_tick = rx_r;
  assign tx_clk_tick = tx_r;

  // ****************************************
  // timer interrupt request
  // ****************************************
  // external flag stays readable in up/down mode but cannot
  // raise timer_irq_req there
  assign ext_irq_ok = ctrl_r[`TMC_B_EXT] & ~down_count_enable_r;

  always_comb begin
    req_nxt = timer_int_en
              & (ctrl_r[`TMC_B_OVF] | ext_irq_ok);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      req_r <= 1'h0;
    end else begin
      req_r <= req_nxt;
    end
  end

  assign timer_irq_req = req_r;

  // ****************************************
  // event status unit
  // ****************************************
  assign irq_bus.evt[`TMC_S_OVF] = ovf_set;
  assign irq_bus.evt[`TMC_S_EXT] = ext_set;
  assign irq_bus.clr_wr = reg_wr & (reg_addr == `TMC_CLR_OFS);
  assign irq_bus.ien_wr = reg_wr & (reg_addr == `TMC_IEN_OFS);
  assign irq_bus.wdata = reg_wdata[1:0];
  assign irq = irq_bus.irq;

  tmc_irq u_irq (
    .clk_sys(clk_sys),
    .srst(srst),
    .bus(irq_bus.unit)
  );

endmodule

// *** hdl/tmc_map.svh ***
/*
 * register offsets, bit positions and reset values of the timer
 * control/status block. assumes nothing; definitions only.
 */
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH
`define TMC_CTRL_OFS 8'hc8
`define TMC_MODE_OFS 8'hc9
`define TMC_STAT_OFS 8'hd0
`define TMC_CLR_OFS 8'hd1
`define TMC_IEN_OFS 8'hd2
`define TMC_BIT_BASE 8'hc8
`define TMC_CTRL_RST 8'h00
`define TMC_DOWN_COUNT_ENABLE_RST 1'h0
`define TMC_IRQ_RST 2'h0
`define TMC_B_OVF 7
`define TMC_B_EXT 6
`define TMC_B_RCLK 5
`define TMC_B_TRANSMIT_CLOCK_SELECT 4
`define TMC_B_EXEN 3
`define TMC_B_RUN 2
`define TMC_B_CT 1
`define TMC_B_CPRL 0
`define TMC_B_DOWN_COUNT_ENABLE 0
`define TMC_S_OVF 0
`define TMC_S_EXT 1
`endif

// *** hdl/tmc_pkg.sv ***
/*
 * types of the timer control/status block.
 * assumes tmc_map.svh supplies the numeric constants.
 */
package tmc_pkg;
  typedef enum logic [3:0] {
    TMC_OFF = 4'h1,
    TMC_RELOAD = 4'h2,
    TMC_CAPTURE = 4'h4,
    TMC_BAUD = 4'h8
  } tmc_mode_t;
endpackage

// *** hdl/tmc_irq_if.sv ***
/*
 * link between the control block and its interrupt status unit.
 * assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps
interface tmc_irq_if;
  logic [1:0] evt;
  logic clr_wr;
  logic ien_wr;
  logic [1:0] wdata;
  logic [1:0] status;
  logic [1:0] ien;
  logic irq;
  modport ctrl(output evt, clr_wr, ien_wr, wdata,
               input status, ien, irq);
  modport unit(input evt, clr_wr, ien_wr, wdata,
               output status, ien, irq);
endinterface

// *** hdl/tmc_irq.sv ***
/*
 * sticky event status, write-only clear, enable, level interrupt.
 * assumes synchronous active-high reset on clk_sys.
 */
`timescale 1ns/1ps
`include "tmc_map.svh"
module tmc_irq
  import tmc_pkg::*;
(
  input wire logic clk_sys, // core clock
  input wire logic srst, // sync reset
  tmc_irq_if.unit bus // event and register link
);
  logic [1:0] status_r;
  logic [1:0] status_nxt;
  logic [1:0] ien_r;
  logic [1:0] ien_nxt;

  // a set arriving with its clear wins
  always_comb begin
    status_nxt = status_r;
    ien_nxt = ien_r;
    if (bus.clr_wr) begin
      status_nxt = status_nxt & ~bus.wdata;
    end
    status_nxt = status_nxt | bus.evt;
    if (bus.ien_wr) begin
      ien_nxt = bus.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_r <= `TMC_IRQ_RST;
      ien_r <= `TMC_IRQ_RST;
    end else begin
      status_r <= status_nxt;
      ien_r <= ien_nxt;
    end
  end

  assign bus.status = status_r;
  assign bus.ien = ien_r;
  assign bus.irq = |(status_r & ien_r);
endmodule

// *** tb/tmc_ctrl_checker.sv ***
/* checker of tmc_ctrl port timing.
   assumes the top ports and tmc_pkg; attached by bind. */
`timescale 1ns/1ps
module tmc_ctrl_checker
  import tmc_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic srst, // reset
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic bit_rd, // bit read
  input wire logic [7:0] reg_rdata, // read data
  input wire logic timer_ovf, // overflow
  input wire logic external_trigger_pin, // trigger
  input wire logic timer_int_en, // int enable
  input wire logic alt_rx_tick, // alt rx
  input wire logic alt_tx_tick, // alt tx
  input wire tmc_mode_t mode, // mode
  input wire logic count_run, // run
  input wire logic capture_pulse, // capture
  input wire logic reload_pulse, // reload
  input wire logic rx_clk_tick, // rx tick
  input wire logic tx_clk_tick, // tx tick
  input wire logic timer_irq_req, // request
  input wire logic irq // status irq
);
  // ********
  // checks
  // ********
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // mode lags ctrl, so only a settled mode is trusted
  sequence s_ovf_taken;
    timer_ovf && mode == TMC_RELOAD && $stable(mode) && timer_int_en
    ##1 timer_int_en;
  endsequence
  a_ovf_irq_req: assert property (s_ovf_taken |=> timer_irq_req)
    else $error("overflow gave no request");
  a_baud_no_flag: assert property (!irq && timer_ovf && !reg_wr &&
    mode == TMC_BAUD && $stable(mode) |=> !irq)
    else $error("overflow flagged in baud mode");
  a_reload_ovf: assert property (timer_ovf && $stable(mode) &&
    mode inside {TMC_RELOAD, TMC_BAUD} |=> reload_pulse)
    else $error("overflow gave no reload");
  a_capture_fall: assert property (capture_pulse
    |-> !$past(external_trigger_pin)) else $error("capture without fall");
  a_rx_source: assert property (rx_clk_tick
    |-> $past(timer_ovf) || $past(alt_rx_tick)) else $error("rx tick");
  a_tx_source: assert property (tx_clk_tick
    |-> $past(timer_ovf) || $past(alt_tx_tick)) else $error("tx tick");
  a_req_needs_en: assert property (timer_irq_req
    |-> $past(timer_int_en)) else $error("request while disabled");
  a_run_mode: assert property (count_run == (mode != TMC_OFF))
    else $error("run and mode disagree");
  a_rdata_idle: assert property (!$past(reg_rd) && !$past(bit_rd)
    |-> reg_rdata == 8'h00) else $error("read data outside slot");
endmodule
bind tmc_ctrl tmc_ctrl_checker tmc_ctrl_checker_i (
  .clk_sys(clk_sys), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .bit_rd(bit_rd), .reg_rdata(reg_rdata), .timer_ovf(timer_ovf),
  .external_trigger_pin(external_trigger_pin), .irq(irq),
  .timer_int_en(timer_int_en), .alt_rx_tick(alt_rx_tick),
  .alt_tx_tick(alt_tx_tick), .mode(mode), .count_run(count_run),
  .capture_pulse(capture_pulse), .reload_pulse(reload_pulse),
  .rx_clk_tick(rx_clk_tick), .tx_clk_tick(tx_clk_tick),
  .timer_irq_req(timer_irq_req)
);

// *** tb/tmc_ctrl_tb.sv ***
/* random testbench of tmc_ctrl with a few fixed corners.
   assumes design files and checker are compiled before it. */
`timescale 1ns/1ps
module tmc_ctrl_tb
  import tmc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, bit_wr = 1'b0, bit_rd = 1'b0;
  logic timer_ovf = 1'b0, external_trigger_pin = 1'b1;
  logic timer_int_en = 1'b0, alt_rx_tick = 1'b0, alt_tx_tick = 1'b0;
  logic [7:0] reg_rdata, c, q, e;
  tmc_mode_t mode, mx;
  logic count_run, count_external, capture_pulse, reload_pulse;
  logic down_count_enable, rx_clk_tick, tx_clk_tick, timer_irq_req, irq;
  logic [3:0] p;
  logic [1:0] w, en;
  logic dc, ie;
  int seed = 80042, miscompares = 0, total_checks = 0;
  tmc_ctrl tmc_ctrl_i (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .bit_wr(bit_wr), .bit_rd(bit_rd), .reg_rdata(reg_rdata),
    .timer_ovf(timer_ovf), .external_trigger_pin(external_trigger_pin),
    .timer_int_en(timer_int_en), .alt_rx_tick(alt_rx_tick),
    .alt_tx_tick(alt_tx_tick), .mode(mode), .count_run(count_run),
    .count_external(count_external), .capture_pulse(capture_pulse),
    .reload_pulse(reload_pulse), .down_count_enable(down_count_enable),
    .rx_clk_tick(rx_clk_tick), .tx_clk_tick(tx_clk_tick),
    .timer_irq_req(timer_irq_req), .irq(irq)
  );
  initial forever #2.5 clk_sys = ~clk_sys;
  // ********
  // helpers
  // ********
  function automatic logic [7:0] ctrl_exp(logic [7:0] c, logic [1:0] w,
                                          logic dc);
    ctrl_exp = c;
    ctrl_exp[7] = w == 2'd0 && !(c[5] | c[4]);
    ctrl_exp[6] = w == 2'd1 && c[3] && !(c[5] | c[4]) && (c[0] || !dc);
  endfunction
  function automatic logic [3:0] pul_exp(logic [7:0] c, logic [1:0] w,
                                         logic dc);
    logic f;
    f = w == 2'd1 && c[3] && !(c[5] | c[4]);
    pul_exp[3] = f && c[0];
    pul_exp[2] = (w == 2'd0 && (c[5] || c[4] || !c[0])) || (f && !c[0] && !dc);
    pul_exp[1] = w == 2'd0 ? c[5] : w == 2'd2 && !c[5];
    pul_exp[0] = w == 2'd0 ? c[4] : w == 2'd3 && !c[4];
  endfunction
  task chk(input string n, input logic [7:0] s, input logic [7:0] x);
    total_checks++;
    if (s !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  // k: 0 write, 1 read, 2 bit write, 3 bit read
  task acc(input int k, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    {reg_wr, reg_rd, bit_wr, bit_rd} <= 4'b1000 >> k;
    @(posedge clk_sys);
    {reg_wr, reg_rd, bit_wr, bit_rd} <= 4'h0;
    #1 q = reg_rdata;
  endtask
  // w: 0 overflow, 1 trigger fall, 2 alt rx, 3 alt tx
  task ev(input logic [1:0] w, input logic ie);
    @(posedge clk_sys);
    timer_int_en <= ie;
    timer_ovf <= w == 2'd0;
    external_trigger_pin <= w != 2'd1;
    alt_rx_tick <= w == 2'd2;
    alt_tx_tick <= w == 2'd3;
    @(posedge clk_sys);
    {timer_ovf, alt_rx_tick, alt_tx_tick} <= 3'h0;
    external_trigger_pin <= 1'b1;
    #1 p = {capture_pulse, reload_pulse, rx_clk_tick, tx_clk_tick};
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ********
  // sequence
  // ********
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    acc(1, 8'hc8, 8'h00);
    chk("ctrl reset", q, 8'h00);
    acc(1, 8'hc0, 8'h00);
    chk("unmapped", q, 8'h00);
    acc(2, 8'hcf, 8'h01);
    acc(3, 8'hcf, 8'h00);
    chk("bit read", q, 8'h01);
    acc(1, 8'hd1, 8'h00);
    chk("clear read", q, 8'h00);
    for (int i = 0; i < 40; i++) begin
      c = 8'($random(seed)) & 8'h3f;
      w = 2'($random(seed));
      dc = 1'($random(seed));
      en = 2'($random(seed));
      ie = 1'($random(seed));
      if (i < 2)
        {c, w, dc} = i ? {8'h0c, 2'd1, 1'b1} : {8'h34, 2'd0, 1'b0};
      mx = !c[2] ? TMC_OFF : (c[5] | c[4]) ? TMC_BAUD :
           c[0] ? TMC_CAPTURE : TMC_RELOAD;
      // flags written to 0 here, so each round starts clean
      acc(0, 8'hc8, c);
      acc(0, 8'hc9, {7'h0, dc});
      acc(0, 8'hd1, 8'h03);
      acc(0, 8'hd2, {6'h0, en});
      ev(w, ie);
      e = ctrl_exp(c, w, dc);
      chk("pulses", {4'h0, p}, {4'h0, pul_exp(c, w, dc)});
      acc(1, 8'hc8, 8'h00);
      chk("ctrl", q, e);
      acc(1, 8'hd0, 8'h00);
      chk("status", q, {6'h0, e[6], e[7]});
      chk("irq", {7'h0, irq}, {7'h0, |({e[6], e[7]} & en)});
      chk("req", {7'h0, timer_irq_req},
          {7'h0, ie && (e[7] || (e[6] && !dc))});
      chk("mode", {4'h0, mode}, {4'h0, mx});
      chk("down_count_enable", {7'h0, down_count_enable}, {7'h0, dc});
      chk("run", {7'h0, count_run}, {7'h0, c[2]});
      chk("ct", {7'h0, count_external}, {7'h0, c[1]});
    end
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    test_done;
  end
endmodule
